// ==== spct_map.svh ====
// Register indices, field positions, reset values and timing counts of the serial port.
`ifndef SPCT_MAP_SVH
`define SPCT_MAP_SVH

`define SPCT_IDX_CTL1     3'h0
`define SPCT_IDX_DATA     3'h2
`define SPCT_IDX_CTL2     3'h3
`define SPCT_IDX_STAT     3'h4
`define SPCT_IDX_IRQ      3'h5
`define SPCT_IDX_MASK     3'h6

`define SPCT_C2_TIE       7
`define SPCT_C2_TX_DONE_IRQ_EN      6
`define SPCT_C2_RIE       5
`define SPCT_C2_IDLE_IRQ_EN      4
`define SPCT_C2_TE        3
`define SPCT_C2_RE        2
`define SPCT_C2_RWU       1
`define SPCT_C2_SBK       0

`define SPCT_C1_LOOP      7
`define SPCT_C1_RX_SOURCE_SEL      5
`define SPCT_C1_NINE      4
`define SPCT_C1_WAKE      3
`define SPCT_C1_LONG_BREAK_SEL     1
`define SPCT_C1_DIR       0

`define SPCT_CTL2_RESET   8'h00
`define SPCT_CTL1_RESET   8'h00
`define SPCT_MASK_RESET   4'hf

`define SPCT_BIT_LAST     5'h0f
`define SPCT_BIT_HALF     5'h07
`define SPCT_FRM8         4'ha
`define SPCT_FRM9         4'hb
`define SPCT_BRK_EXTRA    4'h3

`endif

// ==== spct_pkg.sv ====
// Types shared by the serial port control logic.
`default_nettype none
package spct_pkg;
    typedef enum logic [1:0] {
        SPCT_TX_IDLE  = 2'b00,
        SPCT_TX_DATA  = 2'b01,
        SPCT_TX_BREAK = 2'b10,
        SPCT_TX_PRE   = 2'b11
    } spct_tx_kind_type;

    typedef enum logic [1:0] {
        SPCT_RX_IDLE  = 2'b00,
        SPCT_RX_START = 2'b01,
        SPCT_RX_BITS  = 2'b10
    } spct_rx_state_type;
endpackage
`default_nettype wire

// ==== spct_top.sv ====
// Serial port with its second control register, transmitter, receiver and APB slave.
`include "spct_map.svh"
`default_nettype none

module spct_top (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             irq_out,
    input  wire logic        serial_in_in,
    input  wire logic        serial_out_pin_in,
    output logic             serial_out_out,
    output logic             serial_out_oe_out,
    output logic             tx_pin_owned_out,
    output logic             rx_pin_owned_out
);
    logic [31:0] prdata_r;
    logic [11:0] tx_sh_r;
    logic [9:0]  rx_sh_r;
    logic [8:0]  tx_buf_r, rx_data_r;
    logic [7:0]  ctl1_r, ctl2_r;
    logic [4:0]  tx_tick_r, rx_tick_r;
    logic [3:0]  mask_r, irq_sts_r, tx_cnt_r, rx_cnt_r, idle_bits_r;
    logic        tx_empty_r, tx_done_r, tx_line_r, brk_pend_r, idle_pend_r, own_r, oe_r;
    logic        rx_own_r, in_s1_r, in_s2_r, pin_s1_r, pin_s2_r, rx_full_r, idle_flag_r;
    logic        pready_r, pslverr_r, irq_r;
    spct_pkg::spct_tx_kind_type  tx_kind_r;
    spct_pkg::spct_rx_state_type rx_st_r;
    logic        loop, rx_source_sel, nine, wake, long_break_sel, dir, single;
    logic [3:0]  flen, brk_len;
    logic [2:0]  idx;
    logic        hit, acc, wr, c2_wr, data_wr, data_rd;
    logic        tx_free, load_brk, load_idle, load_data, sbk_rise, te_requeue;
    logic        rx_line, rx_done, rx_msb, deliver, idle_evt, hw_wake, start_seen;
    logic [3:0]  flags, req;
    logic [31:0] rd_mux;
    always_comb begin
        loop    = ctl1_r[`SPCT_C1_LOOP];
        rx_source_sel    = ctl1_r[`SPCT_C1_RX_SOURCE_SEL];
        nine    = ctl1_r[`SPCT_C1_NINE];
        wake    = ctl1_r[`SPCT_C1_WAKE];
        long_break_sel   = ctl1_r[`SPCT_C1_LONG_BREAK_SEL];
        dir     = ctl1_r[`SPCT_C1_DIR];
        single  = loop & rx_source_sel;
        flen    = nine ? `SPCT_FRM9 : `SPCT_FRM8;
        brk_len = flen + (long_break_sel ? `SPCT_BRK_EXTRA : 4'h0);
    end
    // APB decode; every register is one aligned word at four times its index.
    always_comb begin
        idx     = paddr_in[4:2];
        hit     = (paddr_in[1:0] == 2'h0) && (paddr_in[11:5] == 7'h00) &&
                  (idx == `SPCT_IDX_CTL1 || idx == `SPCT_IDX_DATA || idx == `SPCT_IDX_CTL2 ||
                   idx == `SPCT_IDX_STAT || idx == `SPCT_IDX_IRQ || idx == `SPCT_IDX_MASK);
        acc     = psel_in & penable_in & pready_r;
        wr      = acc & pwrite_in & hit;
        c2_wr   = wr & (idx == `SPCT_IDX_CTL2);
        data_wr = wr & (idx == `SPCT_IDX_DATA);
        data_rd = acc & ~pwrite_in & hit & (idx == `SPCT_IDX_DATA);
        flags   = {tx_empty_r, tx_done_r, rx_full_r, idle_flag_r};
        rd_mux  = 32'h0;
        unique case (idx)
            `SPCT_IDX_CTL1: rd_mux = {24'h0, ctl1_r};
            `SPCT_IDX_DATA: rd_mux = {23'h0, rx_data_r};
            `SPCT_IDX_CTL2: rd_mux = {24'h0, ctl2_r};
            `SPCT_IDX_STAT: rd_mux = {24'h0, flags, 4'h0};
            `SPCT_IDX_IRQ:  rd_mux = {24'h0, irq_sts_r, 4'h0};
            `SPCT_IDX_MASK: rd_mux = {24'h0, mask_r, 4'h0};
            default:        rd_mux = 32'h0;
        endcase
    end
    // The slave answers on the second access cycle, so every output stays registered.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            pready_r  <= psel_in & penable_in & ~pready_r;
            pslverr_r <= psel_in & penable_in & ~pready_r & ~hit;
            prdata_r  <= (psel_in & penable_in & ~pready_r & ~pwrite_in & hit) ? rd_mux : 32'h0;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctl1_r <= `SPCT_CTL1_RESET;
            mask_r <= `SPCT_MASK_RESET;
        end else if (wr && idx == `SPCT_IDX_CTL1) begin
            ctl1_r <= pwdata_in[7:0];
        end else if (wr && idx == `SPCT_IDX_MASK) begin
            mask_r <= pwdata_in[7:4];
        end
    end
    // A software write wins over the hardware wakeup clear of rx_standby.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctl2_r <= `SPCT_CTL2_RESET;
        end else if (c2_wr) begin
            ctl2_r <= pwdata_in[7:0];
        end else if (hw_wake) begin
            ctl2_r[`SPCT_C2_RWU] <= 1'b0;
        end
    end
    // Transmitter. Break outranks a queued idle, which outranks data.
    always_comb begin
        tx_free    = (tx_cnt_r == 4'h0);
        sbk_rise   = c2_wr & pwdata_in[`SPCT_C2_SBK] & ~ctl2_r[`SPCT_C2_SBK];
        te_requeue = c2_wr & pwdata_in[`SPCT_C2_TE] & ~ctl2_r[`SPCT_C2_TE] & ~tx_free;
        load_brk   = tx_free & (brk_pend_r | (ctl2_r[`SPCT_C2_TE] & ctl2_r[`SPCT_C2_SBK]));
        load_idle  = tx_free & ~load_brk & idle_pend_r;
        load_data  = tx_free & ~load_brk & ~idle_pend_r & ctl2_r[`SPCT_C2_TE] &
                     ~tx_empty_r & ~data_wr;
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            brk_pend_r  <= 1'b0;
            idle_pend_r <= 1'b0;
        end else begin
            if (sbk_rise && ctl2_r[`SPCT_C2_TE]) begin
                brk_pend_r <= 1'b1;
            end else if (load_brk) begin
                brk_pend_r <= 1'b0;
            end
            if (te_requeue) begin
                idle_pend_r <= 1'b1;
            end else if (load_idle) begin
                idle_pend_r <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_cnt_r  <= 4'h0;
            tx_tick_r <= 5'h00;
            tx_sh_r   <= 12'hfff;
            tx_kind_r <= spct_pkg::SPCT_TX_IDLE;
            tx_line_r <= 1'b1;
        end else begin
            tx_line_r <= tx_free ? 1'b1 :
                         (tx_kind_r == spct_pkg::SPCT_TX_BREAK) ? 1'b0 : tx_sh_r[0];
            if (!tx_free) begin
                if (tx_tick_r == `SPCT_BIT_LAST) begin
                    tx_tick_r <= 5'h00;
                    tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
                    tx_cnt_r  <= tx_cnt_r - 4'h1;
                end else begin
                    tx_tick_r <= tx_tick_r + 5'h01;
                end
            end else if (load_brk) begin
                tx_kind_r <= spct_pkg::SPCT_TX_BREAK;
                tx_cnt_r  <= brk_len;
                tx_tick_r <= 5'h00;
            end else if (load_idle) begin
                tx_kind_r <= spct_pkg::SPCT_TX_PRE;
                tx_sh_r   <= 12'hfff;
                tx_cnt_r  <= flen;
                tx_tick_r <= 5'h00;
            end else if (load_data) begin
                tx_kind_r <= spct_pkg::SPCT_TX_DATA;
                tx_sh_r   <= {2'b11, nine ? tx_buf_r[8] : 1'b1, tx_buf_r[7:0], 1'b0};
                tx_cnt_r  <= flen;
                tx_tick_r <= 5'h00;
            end
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_buf_r   <= 9'h000;
            tx_empty_r <= 1'b1;
            tx_done_r  <= 1'b1;
        end else begin
            if (load_data) begin
                tx_empty_r <= 1'b1;
            end else if (data_wr) begin
                tx_empty_r <= 1'b0;
                tx_buf_r   <= pwdata_in[8:0];
            end
            tx_done_r <= tx_empty_r & tx_free & ~brk_pend_r & ~idle_pend_r &
                         ~(ctl2_r[`SPCT_C2_TE] & ctl2_r[`SPCT_C2_SBK]);
        end
    end
    // Pin ownership: the output stays ours until queued traffic drains.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            own_r    <= 1'b0;
            oe_r     <= 1'b0;
            rx_own_r <= 1'b0;
        end else begin
            own_r    <= ctl2_r[`SPCT_C2_TE] | ~tx_free | brk_pend_r | idle_pend_r;
            oe_r     <= (ctl2_r[`SPCT_C2_TE] | ~tx_free | brk_pend_r | idle_pend_r) &
                        ~(single & ~dir);
            rx_own_r <= ctl2_r[`SPCT_C2_RE] & ~loop;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            in_s1_r  <= 1'b1;
            in_s2_r  <= 1'b1;
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end else begin
            in_s1_r  <= serial_in_in;
            in_s2_r  <= in_s1_r;
            pin_s1_r <= serial_out_pin_in;
            pin_s2_r <= pin_s1_r;
        end
    end
    // Receiver. Loopback feeds it from the transmitter or, in single-wire receive, the shared line.
    always_comb begin
        rx_line    = loop ? ((rx_source_sel & ~dir) ? pin_s2_r : tx_line_r) : in_s2_r;
        rx_done    = (rx_st_r == spct_pkg::SPCT_RX_BITS) && (rx_tick_r == `SPCT_BIT_LAST) &&
                     (rx_cnt_r == flen - 4'h2);
        rx_msb     = nine ? rx_sh_r[8] : rx_sh_r[7];
        deliver    = rx_done & (~ctl2_r[`SPCT_C2_RWU] | (wake & rx_msb));
        idle_evt   = (rx_st_r == spct_pkg::SPCT_RX_IDLE) && rx_line &&
                     (rx_tick_r == `SPCT_BIT_LAST) && (idle_bits_r == flen - 4'h1);
        start_seen = (rx_st_r == spct_pkg::SPCT_RX_IDLE) && !rx_line;
        hw_wake    = ctl2_r[`SPCT_C2_RWU] &
                     ((~wake & idle_evt) | (wake & rx_done & rx_msb));
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_st_r     <= spct_pkg::SPCT_RX_IDLE;
            rx_tick_r   <= 5'h00;
            rx_cnt_r    <= 4'h0;
            rx_sh_r     <= 10'h000;
            idle_bits_r <= `SPCT_FRM9;
        end else if (!ctl2_r[`SPCT_C2_RE]) begin
            rx_st_r   <= spct_pkg::SPCT_RX_IDLE;
            rx_tick_r <= 5'h00;
        end else begin
            unique case (rx_st_r)
                spct_pkg::SPCT_RX_IDLE: begin
                    if (!rx_line) begin
                        rx_st_r   <= spct_pkg::SPCT_RX_START;
                        rx_tick_r <= 5'h00;
                    end else if (rx_tick_r == `SPCT_BIT_LAST) begin
                        rx_tick_r <= 5'h00;
                        if (idle_bits_r < flen) begin
                            idle_bits_r <= idle_bits_r + 4'h1;
                        end
                    end else begin
                        rx_tick_r <= rx_tick_r + 5'h01;
                    end
                end
                spct_pkg::SPCT_RX_START: begin
                    if (rx_tick_r == `SPCT_BIT_HALF) begin
                        rx_st_r   <= rx_line ? spct_pkg::SPCT_RX_IDLE : spct_pkg::SPCT_RX_BITS;
                        rx_tick_r <= 5'h00;
                        rx_cnt_r  <= 4'h0;
                    end else begin
                        rx_tick_r <= rx_tick_r + 5'h01;
                    end
                end
                spct_pkg::SPCT_RX_BITS: begin
                    if (rx_tick_r == `SPCT_BIT_LAST) begin
                        rx_tick_r         <= 5'h00;
                        rx_sh_r[rx_cnt_r] <= rx_line;
                        rx_cnt_r          <= rx_cnt_r + 4'h1;
                        if (rx_done) begin
                            rx_st_r     <= spct_pkg::SPCT_RX_IDLE;
                            idle_bits_r <= 4'h0;
                        end
                    end else begin
                        rx_tick_r <= rx_tick_r + 5'h01;
                    end
                end
                default: rx_st_r <= spct_pkg::SPCT_RX_IDLE;
            endcase
        end
    end
    // Flags: a hardware set wins over the clear in the same cycle.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_data_r   <= 9'h000;
            rx_full_r   <= 1'b0;
            idle_flag_r <= 1'b0;
        end else begin
            if (deliver) begin
                rx_data_r <= {nine & rx_sh_r[8], rx_sh_r[7:0]};
                rx_full_r <= 1'b1;
            end else if (data_rd) begin
                rx_full_r <= 1'b0;
            end
            if (idle_evt && !ctl2_r[`SPCT_C2_RWU]) begin
                idle_flag_r <= 1'b1;
            end else if (start_seen) begin
                idle_flag_r <= 1'b0;
            end
        end
    end
    // Interrupts: enabled flags set sticky bits, cleared by writing one, gated by the mask.
    assign req = flags & ctl2_r[7:4];
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_sts_r <= 4'h0;
            irq_r     <= 1'b0;
        end else begin
            irq_sts_r <= (irq_sts_r & ~((wr && idx == `SPCT_IDX_IRQ) ? pwdata_in[7:4] : 4'h0))
                         | req;
            irq_r     <= |(irq_sts_r & mask_r);
        end
    end

    assign {prdata_out, pready_out}             = {prdata_r, pready_r};
    assign {pslverr_out, irq_out}               = {pslverr_r, irq_r};
    assign {serial_out_out, serial_out_oe_out}  = {tx_line_r, oe_r};
    assign {tx_pin_owned_out, rx_pin_owned_out} = {own_r, rx_own_r};

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_brk_load;
        load_brk;
    endsequence
    sequence s_brk_run;
        (tx_kind_r == spct_pkg::SPCT_TX_BREAK) && (tx_cnt_r == $past(brk_len));
    endsequence

    ctl2_write_a: assert property (c2_wr |=> ctl2_r == $past(pwdata_in[7:0]))
        else $error("control two did not take the written value");
    tx_empty_irq_a: assert property (tx_empty_r && ctl2_r[7] |=> irq_sts_r[3])
        else $error("transmit-empty request not raised");
    tx_done_irq_a: assert property (tx_done_r && ctl2_r[6] |=> irq_sts_r[2])
        else $error("transmit-done request not raised");
    rx_full_irq_a: assert property (rx_full_r && ctl2_r[5] |=> irq_sts_r[1])
        else $error("receive-full request not raised");
    idle_irq_a: assert property (idle_flag_r && !ctl2_r[4] |=> !req[0])
        else $error("idle request raised while disabled");
    irq_level_a: assert property (|(irq_sts_r & mask_r) |=> irq_out)
        else $error("interrupt output not asserted");
    pin_hold_a: assert property (!tx_free |=> tx_pin_owned_out)
        else $error("output pin released during traffic");
    rx_pin_a: assert property (loop |=> !rx_pin_owned_out)
        else $error("input pin kept in loopback");
    break_len_a: assert property (s_brk_load |=> s_brk_run)
        else $error("break length wrong");
    wake_idle_a: assert property (hw_wake && !c2_wr |=> !ctl2_r[1])
        else $error("standby not cleared on wakeup");
endmodule
`default_nettype wire

// ==== spct_remote.sv ====
// Behavioural remote serial transceiver: decodes our transmit line and sends frames to us.
`default_nettype none

module spct_remote (
    input  wire logic clk_in,
    input  wire logic line_in,
    output logic      line_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got_byte;
    int         frames   = 0;
    int         breaks   = 0;
    int         low_run  = 0;
    int         last_low = 0;

    initial line_out = 1'b1;

    // Length of the last low stretch, used to time break characters.
    always @(posedge clk_in) begin
        if (!line_in) begin
            low_run <= low_run + 1;
        end else begin
            if (low_run != 0) last_low <= low_run;
            low_run <= 0;
        end
    end

    // Start bit taken on the first low clock with no mid-bit check, then eight data bits lsb first, then the stop bit.
    always begin
        @(posedge clk_in iff !line_in);
        repeat (8) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clk_in);
            got_byte[i] = line_in;
        end
        repeat (16) @(posedge clk_in);
        if (line_in) begin
            frames++;
        end else begin
            while (!line_in) @(posedge clk_in);
            breaks++;
        end
    end

    // Sends one eight-bit frame; each bit stands for 16 clocks.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (16) @(posedge clk_in);
        end
    endtask
endmodule

`default_nettype wire

// ==== spct_top_tb_top.sv ====
// Self-checking testbench of the serial port control block.
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin num_errors++; $display("FAIL %s expected %h seen %h", nm, ex, gt); end end

module spct_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        rx_line;
    logic        tx_out;
    logic        tx_oe;
    logic        tx_owned;
    logic        rx_owned;
    logic        line_w;
    logic [31:0] q;
    logic        e;
    int          num_errors = 0;
    int          total_checks = 0;
    int          n;

    // The shared transmit line has a pull-up while nobody drives it.
    assign line_w = tx_oe ? tx_out : 1'b1;

    always #25 clk = ~clk;

    spct_top spct_top_inst (
        .clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq), .serial_in_in(rx_line),
        .serial_out_pin_in(line_w), .serial_out_out(tx_out), .serial_out_oe_out(tx_oe),
        .tx_pin_owned_out(tx_owned), .rx_pin_owned_out(rx_owned)
    );

    spct_remote spct_remote_inst (.clk_in(clk), .line_in(line_w), .line_out(rx_line));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic bad_wait();
        num_errors++;
        $display("FAIL wait expected done seen timeout");
        report_and_stop();
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) bad_wait();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wait_irq(input logic ex);
        for (int k = 0; k < 8 && irq !== ex; k++) @(posedge clk);
        `CHK("irq", ex, irq)
    endtask

    task automatic wait_cnt(input int kind, input int target);
        int k;
        for (k = 0; k < 4000; k++) begin
            if ((kind == 0 ? spct_remote_inst.frames : spct_remote_inst.breaks) == target) break;
            @(posedge clk);
        end
        if (k >= 4000) bad_wait();
        repeat (2) @(posedge clk);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(12'h00c);
        `CHK("ctl2", 32'h0, q)
        wr(12'h00c, 8'hf0);
        rd(12'h00c);
        `CHK("ctl2", 32'hf0, q)
        rd(12'h004);
        `CHK("unmapped", 1'b1, e)
        wr(12'h00c, 8'h00);
        wr(12'h014, 8'hf0);
        wait_irq(1'b0);
        wr(12'h00c, 8'h80);
        wait_irq(1'b1);
        wr(12'h018, 8'h00);
        wait_irq(1'b0);
        wr(12'h018, 8'hf0);
        wr(12'h00c, 8'h40);
        wr(12'h014, 8'hf0);
        rd(12'h014);
        `CHK("irqstat", 32'h40, q)
        wait_irq(1'b1);
        wr(12'h00c, 8'h0c);
        wr(12'h014, 8'hf0);
        wait_irq(1'b0);
        `CHK("oe", 1'b1, tx_oe)
        `CHK("rxown", 1'b1, rx_owned)
        wr(12'h008, 8'ha5);
        wait_cnt(0, 1);
        `CHK("txbyte", 8'ha5, spct_remote_inst.got_byte)
        wr(12'h008, 8'h3c);
        wr(12'h00c, 8'h04);
        `CHK("txown", 1'b1, tx_owned)
        wait_cnt(0, 2);
        `CHK("txbyte", 8'h3c, spct_remote_inst.got_byte)
        for (n = 0; n < 40 && tx_owned !== 1'b0; n++) @(posedge clk);
        `CHK("txown", 1'b0, tx_owned)
        wr(12'h008, 8'h11);
        wr(12'h00c, 8'h0c);
        repeat (40) @(posedge clk);
        wr(12'h00c, 8'h04);
        wr(12'h00c, 8'h0c);
        wait_cnt(0, 3);
        repeat (40) @(posedge clk);
        rd(12'h010);
        `CHK("status", 32'h80, q)
        wr(12'h00c, 8'h34);
        spct_remote_inst.send(8'h5a);
        wait_irq(1'b1);
        rd(12'h008);
        `CHK("rxdata", 32'h5a, q)
        repeat (400) @(posedge clk);
        rd(12'h014);
        `CHK("irqstat", 32'h30, q)
        wr(12'h00c, 8'h06);
        spct_remote_inst.send(8'h33);
        repeat (400) @(posedge clk);
        rd(12'h00c);
        `CHK("ctl2", 32'h04, q)
        wr(12'h000, 8'h08);
        wr(12'h00c, 8'h06);
        spct_remote_inst.send(8'h12);
        repeat (400) @(posedge clk);
        rd(12'h00c);
        `CHK("ctl2", 32'h06, q)
        spct_remote_inst.send(8'h92);
        repeat (40) @(posedge clk);
        rd(12'h00c);
        `CHK("ctl2", 32'h04, q)
        rd(12'h008);
        `CHK("rxdata", 32'h92, q)
        wr(12'h00c, 8'h08);
        wr(12'h00c, 8'h09);
        wr(12'h00c, 8'h08);
        wait_cnt(1, 1);
        `CHK("brklen", 1'b1, spct_remote_inst.last_low inside {[158:194]})
        repeat (200) @(posedge clk);
        `CHK("brkcnt", 1, spct_remote_inst.breaks)
        wr(12'h000, 8'h02);
        wr(12'h00c, 8'h09);
        wr(12'h00c, 8'h08);
        wait_cnt(1, 2);
        `CHK("brklen", 1'b1, spct_remote_inst.last_low inside {[206:242]})
        wr(12'h000, 8'ha1);
        repeat (2) @(posedge clk);
        `CHK("oe", 1'b1, tx_oe)
        wr(12'h00c, 8'h0c);
        `CHK("rxown", 1'b0, rx_owned)
        wr(12'h000, 8'ha0);
        repeat (2) @(posedge clk);
        `CHK("oe", 1'b0, tx_oe)
        report_and_stop();
    end
endmodule

`default_nettype wire
